// ===== pwt_defines.svh
// register offsets, field positions, reset values and write masks of the pwm timer
// assumes a byte address bus with one 32-bit word per register
`ifndef PWT_DEFINES_SVH
`define PWT_DEFINES_SVH

// register byte offsets
`define PWT_OFS_CLKEN   8'h00
`define PWT_OFS_PSC     8'h04
`define PWT_OFS_IFLAG   8'h08
`define PWT_OFS_IMASK   8'h0c
`define PWT_OFS_CTL     8'h10
`define PWT_OFS_LVL     8'h14
`define PWT_OFS_FSC     8'h18
`define PWT_OFS_SIC     8'h1c
`define PWT_OFS_PERIOD  8'h20
`define PWT_OFS_DUTY    8'h24
`define PWT_OFS_REL     8'h28
`define PWT_OFS_STAT    8'h2c

// field positions
`define PWT_BIT_CLKEN   0
`define PWT_BIT_IRQ     5
`define PWT_BIT_RUN     7
`define PWT_BIT_CKS     4
`define PWT_BIT_FCM     8
`define PWT_BIT_X_EXTB  15
`define PWT_BIT_X_EXTA  14
`define PWT_BIT_X_CMPB  13
`define PWT_BIT_X_CMPA  12
`define PWT_BIT_H_CMPB  5
`define PWT_BIT_H_CMPA  4

// reset values and writable bits
`define PWT_RST_IMASK   1'b1
`define PWT_RST_PERIOD  16'h00ff
`define PWT_RST_DUTY    16'h0080
`define PWT_CNT_STOP    16'hffff
`define PWT_FSC_WMASK   16'hf13f

// bus responses
`define PWT_RESP_OKAY   2'b00
`define PWT_RESP_SLVERR 2'b10

`endif

// ===== pwt_pkg.sv
// types shared by the pwm timer modules
// assumes pwt_defines.svh is available on the include path
package pwt_pkg;

  // operation mode codes
  typedef enum logic [1:0] {
    PWT_MODE_STANDALONE = 2'b00,
    PWT_MODE_INTERLEAVE = 2'b11
  } pwt_mode_t;

  // trigger sources that may force the outputs to stop
  typedef struct packed {
    logic ext_irq_input_b;
    logic ext_irq_input_a;
    logic comparator_b_output;
    logic comparator_a_output;
  } pwt_trig_t;

  // the two timer output pins, level and output enable
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } pwt_pins_t;

endpackage

// ===== pwt_prescaler.sv
// operation clock prescaler: turns aclk into a one-cycle tick at the selected rate
// assumes selection fields come from registers in the same clock domain
`timescale 1ns/1ps
`include "pwt_defines.svh"
module pwt_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_supply,
  input wire logic [2:0] sel_a,
  input wire logic [2:0] sel_b,
  input wire logic src_b,
  output logic tick
);
  import pwt_pkg::*;

  logic [4:0] div_q;
  logic [4:0] div_d;
  logic tick_q;
  logic tick_d;

  // true when the divider reaches the end of a 2^sel span; code 000 ticks every cycle
  function automatic logic span_end(input logic [4:0] cnt, input logic [2:0] sel);
    logic [4:0] mask;
    mask = 5'h00;
    case (sel)
      3'h0: mask = 5'h00;
      3'h1: mask = 5'h01;
      3'h2: mask = 5'h03;
      3'h3: mask = 5'h07;
      3'h4: mask = 5'h0f;
      default: mask = 5'h1f; // prohibited codes run at the slowest rate
    endcase
    return (cnt & mask) == mask;
  endfunction

  // divider stops with the clock supply, source bit picks clock a or b
  always_comb begin
    div_d = div_q;
    tick_d = 1'b0;
    if (clk_supply) begin
      div_d = div_q + 5'h01;
      tick_d = src_b ? span_end(div_q, sel_b) : span_end(div_q, sel_a);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_DIV2_ALTERNATES: assert property (
    (clk_supply && !src_b && sel_a == 3'h1 && $stable(sel_a) && tick_q)
      |=> (clk_supply && sel_a == 3'h1) |-> !tick_q)
    else $error("divide by two ticked twice in a row");
  AST_NO_TICK_GATED: assert property (
    !clk_supply |=> !tick_q)
    else $error("tick seen with clock supply off");
  AST_SRC_B_FULL: assert property (
    (clk_supply && src_b && sel_b == 3'h0) |=> tick_q)
    else $error("clock b at full rate missed a tick");

endmodule

// ===== pwt_timer.sv
// pwm timer setup block: clock gate, prescaler, run control, output levels,
// interrupt flag and mask, and forced stop of both outputs by trigger inputs.
// assumes an axi4-lite master on aclk and trigger inputs synchronous to aclk.
// Behaviour
// - clock supply bit gates timer clock
// - prescaler a: full rate or divide 2..32
// - clock source bit picks prescaler a/b
// - flag sets on request, software writes zero
// - mask bit one withholds interrupt servicing
// - run bit zero stops, loads all ones
// - run bit one lets counter count
// - mode 00 standalone, 11 interleaved outputs
// - active level bit zero means high
// - default level bit selects low/high idle
// - ext irq b selectable for stop two
// - ext irq a selectable for stop two
// - comparator b selectable for stop two
// - comparator a selectable for stop two
// - control holds stop one selects, clear, state
// - separate register gates triggers per output
// - input enable zero disables output stop
// - stop two clears at period, optionally reverse-edge
// - clear code 00 releases on write
// - stopped timer keeps forced stop state
`timescale 1ns/1ps
`include "pwt_defines.svh"
module pwt_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pwt_pkg::pwt_trig_t stop_triggers,
  output pwt_pkg::pwt_pins_t pwm_pins,
  output logic irq_pending
);
  import pwt_pkg::*;

  // register file state
  logic clken_q, clken_d;
  logic [2:0] psel_a_q, psel_a_d, psel_b_q, psel_b_d;
  logic irq_flag_q, irq_flag_d, irq_mask_q, irq_mask_d;
  logic run_q, run_d, cks_q, cks_d;
  pwt_mode_t mode_q, mode_d;
  logic [3:0] lvl_q, lvl_d;
  logic [15:0] fsc_q, fsc_d, period_q, period_d, duty_q, duty_d;
  logic [1:0] sic_q, sic_d;
  // bus state
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_write, rel_wr;
  // timer and forced stop state
  logic tick;
  logic [15:0] cnt_q, cnt_d;
  logic period_end;
  logic trig1_q, trig1_d, trig2_q, trig2_d, trig1, trig2, rise1, rise2, fall2;
  logic rel_pend_q, rel_pend_d, rev_seen_q, rev_seen_d, rel_ok;
  logic [1:0] stop1_q, stop1_d, stop2_q, stop2_d;
  pwt_pins_t pins_q, pins_d;
  logic irq_pend_q, irq_pend_d;
  logic [1:0] act;
  logic [15:0] half, phase;

  // address decode shared by read and write paths
  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `PWT_OFS_STAT);
  endfunction

  // byte-lane merge of the low two lanes into a 16-bit register
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // register read view
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      `PWT_OFS_CLKEN: v[`PWT_BIT_CLKEN] = clken_q;
      `PWT_OFS_PSC: v[6:0] = {psel_b_q, 1'b0, psel_a_q};
      `PWT_OFS_IFLAG: v[`PWT_BIT_IRQ] = irq_flag_q;
      `PWT_OFS_IMASK: v[`PWT_BIT_IRQ] = irq_mask_q;
      `PWT_OFS_CTL: v[7:0] = {run_q, 2'b00, cks_q, 2'b00, mode_q};
      `PWT_OFS_LVL: v[3:0] = lvl_q;
      `PWT_OFS_FSC: v[15:0] = fsc_q;
      `PWT_OFS_SIC: v[1:0] = sic_q;
      `PWT_OFS_PERIOD: v[15:0] = period_q;
      `PWT_OFS_DUTY: v[15:0] = duty_q;
      `PWT_OFS_STAT: v[19:0] = {stop2_q, stop1_q, cnt_q};
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  // write channel capture: address and data taken in either order, response after both
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    do_write = aw_full_q && w_full_q && !bvalid_q;
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = addr_ok(awaddr_q) ? `PWT_RESP_OKAY : `PWT_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d = !w_full_d && !bvalid_d;
  end

  // read channel: one read at a time, data registered with the valid
  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = rd_word(s_axi_araddr);
      rresp_d = addr_ok(s_axi_araddr) ? `PWT_RESP_OKAY : `PWT_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `PWT_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `PWT_RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // register updates from bus writes; the hardware set of the flag wins over a clear
  always_comb begin
    clken_d = clken_q;
    psel_a_d = psel_a_q;
    psel_b_d = psel_b_q;
    irq_mask_d = irq_mask_q;
    run_d = run_q;
    cks_d = cks_q;
    mode_d = mode_q;
    lvl_d = lvl_q;
    fsc_d = fsc_q;
    sic_d = sic_q;
    period_d = period_q;
    duty_d = duty_q;
    irq_flag_d = irq_flag_q;
    rel_wr = 1'b0;
    if (do_write && wstrb_q[0]) begin
      case (awaddr_q)
        `PWT_OFS_CLKEN: clken_d = wdata_q[`PWT_BIT_CLKEN];
        `PWT_OFS_PSC: begin
          psel_a_d = wdata_q[2:0];
          psel_b_d = wdata_q[6:4];
        end
        `PWT_OFS_IFLAG: if (!wdata_q[`PWT_BIT_IRQ]) irq_flag_d = 1'b0;
        `PWT_OFS_IMASK: irq_mask_d = wdata_q[`PWT_BIT_IRQ];
        `PWT_OFS_CTL: begin
          run_d = wdata_q[`PWT_BIT_RUN];
          cks_d = wdata_q[`PWT_BIT_CKS];
          mode_d = pwt_mode_t'(wdata_q[1:0]);
        end
        `PWT_OFS_LVL: lvl_d = wdata_q[3:0];
        `PWT_OFS_SIC: sic_d = wdata_q[1:0];
        `PWT_OFS_REL: rel_wr = wdata_q[0];
        default: ;
      endcase
    end
    if (do_write) begin
      case (awaddr_q)
        `PWT_OFS_FSC: fsc_d = wmerge(fsc_q, wdata_q, wstrb_q) & `PWT_FSC_WMASK;
        `PWT_OFS_PERIOD: period_d = wmerge(period_q, wdata_q, wstrb_q);
        `PWT_OFS_DUTY: duty_d = wmerge(duty_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
    if (period_end) irq_flag_d = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clken_q <= 1'b0;
      psel_a_q <= 3'h0;
      psel_b_q <= 3'h0;
      irq_flag_q <= 1'b0;
      irq_mask_q <= `PWT_RST_IMASK;
      run_q <= 1'b0;
      cks_q <= 1'b0;
      mode_q <= PWT_MODE_STANDALONE;
      lvl_q <= 4'h0;
      fsc_q <= 16'h0;
      sic_q <= 2'h0;
      period_q <= `PWT_RST_PERIOD;
      duty_q <= `PWT_RST_DUTY;
    end else begin
      clken_q <= clken_d;
      psel_a_q <= psel_a_d;
      psel_b_q <= psel_b_d;
      irq_flag_q <= irq_flag_d;
      irq_mask_q <= irq_mask_d;
      run_q <= run_d;
      cks_q <= cks_d;
      mode_q <= mode_d;
      lvl_q <= lvl_d;
      fsc_q <= fsc_d;
      sic_q <= sic_d;
      period_q <= period_d;
      duty_q <= duty_d;
    end
  end

  // operation clock tick
  pwt_prescaler u_psc (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_supply(clken_q),
    .sel_a(psel_a_q),
    .sel_b(psel_b_q),
    .src_b(cks_q),
    .tick(tick)
  );

  // counter: all ones while stopped, counts 0..period on ticks while running
  assign period_end = run_q && tick && (cnt_q == period_q);
  always_comb begin
    cnt_d = cnt_q;
    if (!run_q) begin
      cnt_d = `PWT_CNT_STOP;
    end else if (tick) begin
      cnt_d = (cnt_q == period_q) ? 16'h0 : cnt_q + 16'h1;
    end
  end

  // trigger selection; enables for stop two cover both ext irqs and both comparators
  assign trig1 = (stop_triggers.comparator_a_output && fsc_q[`PWT_BIT_H_CMPA]) ||
                 (stop_triggers.comparator_b_output && fsc_q[`PWT_BIT_H_CMPB]);
  assign trig2 = (stop_triggers.ext_irq_input_b && fsc_q[`PWT_BIT_X_EXTB]) ||
                 (stop_triggers.ext_irq_input_a && fsc_q[`PWT_BIT_X_EXTA]) ||
                 (stop_triggers.comparator_b_output && fsc_q[`PWT_BIT_X_CMPB]) ||
                 (stop_triggers.comparator_a_output && fsc_q[`PWT_BIT_X_CMPA]);
  assign rise1 = trig1 && !trig1_q;
  assign rise2 = trig2 && !trig2_q;
  assign fall2 = !trig2 && trig2_q;
  // a release write is refused while the trigger is active under codes x1
  assign rel_ok = rel_wr && !(fsc_q[2] && trig1);

  // forced stop state per output; a new trigger wins over a release or period-end clear in the same cycle, input enable zero wins over it
  always_comb begin
    trig1_d = trig1;
    trig2_d = trig2;
    rel_pend_d = rel_pend_q;
    rev_seen_d = rev_seen_q;
    if (fsc_q[3] && rel_ok) rel_pend_d = 1'b1;
    else if (period_end) rel_pend_d = 1'b0; // period end only while running
    if (rise2) rev_seen_d = 1'b0;
    else if (fall2) rev_seen_d = 1'b1;
    for (int n = 0; n < 2; n++) begin
      stop1_d[n] = stop1_q[n];
      stop2_d[n] = stop2_q[n];
      if (!sic_q[n]) begin
        stop1_d[n] = 1'b0;
        stop2_d[n] = 1'b0;
      end else begin
        if (rise1) stop1_d[n] = 1'b1;
        else if (!fsc_q[3] && rel_ok) stop1_d[n] = 1'b0;
        else if (fsc_q[3] && rel_pend_q && period_end) stop1_d[n] = 1'b0;
        if (rise2) stop2_d[n] = 1'b1;
        else if (period_end && (!fsc_q[`PWT_BIT_FCM] || rev_seen_q)) stop2_d[n] = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= `PWT_CNT_STOP;
      trig1_q <= 1'b0;
      trig2_q <= 1'b0;
      rel_pend_q <= 1'b0;
      rev_seen_q <= 1'b0;
      stop1_q <= 2'h0;
      stop2_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
      trig1_q <= trig1_d;
      trig2_q <= trig2_d;
      rel_pend_q <= rel_pend_d;
      rev_seen_q <= rev_seen_d;
      stop1_q <= stop1_d;
      stop2_q <= stop2_d;
    end
  end

  // pwm waveform; interleave mode shifts output one by half a period
  assign half = period_q >> 1;
  assign phase = (cnt_q >= half) ? cnt_q - half : cnt_q + (period_q - half) + 16'h1;
  assign act[0] = cnt_q < duty_q;
  assign act[1] = (mode_q == PWT_MODE_INTERLEAVE) ? (phase < duty_q) : act[0];

  // output pins: stop one over stop two over pwm over default level
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      pins_d.oe[n] = 1'b1;
      pins_d.out[n] = lvl_q[n];
      if (stop1_q[n]) begin
        pins_d.oe[n] = fsc_q[1];
        pins_d.out[n] = fsc_q[1] && fsc_q[0];
      end else if (stop2_q[n]) begin
        pins_d.out[n] = fsc_q[0];
      end else if (run_q && clken_q) begin
        pins_d.out[n] = act[n] ^ lvl_q[2 + n];
      end
    end
    irq_pend_d = irq_flag_q && !irq_mask_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_q <= '{out: 2'h0, oe: 2'h3};
      irq_pend_q <= 1'b0;
    end else begin
      pins_q <= pins_d;
      irq_pend_q <= irq_pend_d;
    end
  end

  assign pwm_pins = pins_q;
  assign irq_pending = irq_pend_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // checks of counter, interrupt and forced stop behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_STOP_LOADS_ONES: assert property (
    !run_q |=> cnt_q == 16'hffff)
    else $error("stopped counter is not all ones");
  AST_COUNT_STEPS: assert property (
    (run_q && tick && cnt_q != period_q) |=> cnt_q == $past(cnt_q) + 16'h1)
    else $error("running counter did not advance on a tick");
  AST_IRQ_ON_PERIOD: assert property (
    period_end |=> irq_flag_q ##1 (irq_flag_q || $past(do_write)))
    else $error("period end did not raise the request flag");
  AST_MASK_WITHHOLDS: assert property (
    (irq_flag_q && irq_mask_q) |=> !irq_pending)
    else $error("masked request reached the interrupt output");
  AST_IDLE_DEFAULT: assert property (
    (!run_q && stop1_q == 2'h0 && stop2_q == 2'h0) |=> pwm_pins.out == $past(lvl_q[1:0]))
    else $error("idle output differs from default level");
  AST_HIZ_ON_STOP1: assert property (
    (stop1_q[0] && !fsc_q[1]) |=> !pwm_pins.oe[0])
    else $error("stop one in hi-z state still drives the pin");
  AST_HELD_WHILE_STOPPED: assert property (
    (!run_q && stop2_q[0] && sic_q[0]) |=> stop2_q[0])
    else $error("stop two released while the timer is stopped");
  AST_DISABLED_NO_STOP: assert property (
    !sic_q[1] |=> (stop1_q[1] == 1'b0 && stop2_q[1] == 1'b0))
    else $error("forced stop active on a disabled output");
  AST_RELEASE_ON_WRITE: assert property (
    (rel_wr && fsc_q[3:2] == 2'b00 && !rise1 && stop1_q[0] && sic_q[0]) |=> !stop1_q[0])
    else $error("release write did not end stop one");
  AST_TRIG2_STARTS: assert property (
    (rise2 && sic_q[0]) |=> stop2_q[0] [*1] ##1
      (stop2_q[0] || $past(period_end) || !$past(sic_q[0])))
    else $error("selected trigger did not start stop two");

  COV_PERIOD_END: cover property (period_end ##[1:20] period_end);
  COV_STOP1_RELEASE: cover property (stop1_q[0] ##[1:50] !stop1_q[0]);
  COV_STOP2_CLEAR: cover property (rise2 ##[1:100] $fell(stop2_q[0]));
  COV_IRQ_OUT: cover property ($rose(irq_pending));

endmodule

// ===== pwt_trig_model.sv
// trigger source model: comparator and external interrupt lines for forced stop
// assumes requests arrive as one-cycle pulses on fire, synchronous to aclk
`timescale 1ns/1ps
module pwt_trig_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] fire,
  output pwt_pkg::pwt_trig_t trig
);
  import pwt_pkg::*;
  logic [1:0] cnt_q;

  // hold a requested level for four cycles, then fall back to inactive low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig <= '0;
      cnt_q <= 2'h0;
    end else if (fire != 4'h0) begin
      trig <= fire;
      cnt_q <= 2'h3;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end else begin
      trig <= '0;
    end
  end
endmodule

// ===== pwt_timer_tb.sv
// self-checking bench of the pwm timer: register model, forced stop, counting
// assumes the axi4-lite slave and trigger inputs of pwt_timer on one 100 MHz clock
`timescale 1ns/1ps
module pwt_timer_tb;
  import pwt_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v, v2;
  logic awready, wready, bvalid, arready, rvalid, irq_pending;
  logic [1:0] bresp, rresp;
  logic [3:0] fire = 4'h0;
  pwt_trig_t trig;
  pwt_pins_t pins;
  int n_fail = 0, compares = 0, seed = 20, i, j, l, e, dv;
  int unsigned mdl [8];
  int unsigned wm [8] = '{32'h1, 32'h77, 32'h20, 32'h20, 32'h93, 32'hf, 32'hf13f, 32'h3};

  pwt_trig_model pwt_trig_model_i (.aclk(aclk), .aresetn(aresetn), .fire(fire), .trig(trig));
  pwt_timer pwt_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stop_triggers(trig), .pwm_pins(pins), .irq_pending(irq_pending));

  // 100 MHz clock
  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // axi write: offer address and data together, release each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (k == 40) begin
      n_fail++;
      finish_test();
    end
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    if (a < 8'h20) mdl[a[4:2]] = d & wm[a[4:2]];
  endtask

  // axi read: hold rready until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    chk("rresp", {30'h0, rresp}, (a[1:0] == 2'b00 && a <= 8'h2c) ? 32'h0 : 32'h2);
    rready <= 1'b0;
    if (k == 40) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] d;
    rd(a, d);
    chk("rdata", d & m, x);
  endtask

  // one-cycle request to the trigger model, then let the stop settle
  task automatic pulse(input int t);
    @(posedge aclk);
    fire <= 4'h1 << t;
    @(posedge aclk);
    fire <= 4'h0;
    repeat (6) @(posedge aclk);
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge aclk);
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h0c, 32'hffffffff, 32'h20);
    rchk(8'h2c, 32'hffff, 32'hffff);
    // random values through the register model, unmapped place refused
    for (i = 0; i < 8; i++) begin
      if (i == 2) continue;
      wr(8'(i * 4), $random(seed), 2'b00);
      rchk(8'(i * 4), 32'hffffffff, mdl[i]);
    end
    wr(8'h30, 32'h1, 2'b10);
    rchk(8'h30, 32'hffffffff, 32'h0);
    wr(8'h10, 32'h0, 2'b00);
    wr(8'h00, 32'h0, 2'b00);
    wr(8'h18, 32'h0, 2'b00);
    // idle levels with the timer stopped
    for (i = 0; i < 4; i++) begin
      wr(8'h14, i, 2'b00);
      repeat (3) @(posedge aclk);
      chk("out", pins.out, 32'(i));
      chk("oe", pins.oe, 32'h3);
    end
    // stop one: comparator a, hi-z state, released by software
    wr(8'h1c, 32'h3, 2'b00);
    wr(8'h18, 32'h10, 2'b00);
    pulse(0);
    chk("oe", pins.oe, 32'h0);
    wr(8'h28, 32'h1, 2'b00);
    repeat (3) @(posedge aclk);
    chk("oe", pins.oe, 32'h3);
    // stop two: each trigger source, selected and not selected
    wr(8'h14, 32'h0, 2'b00);
    for (j = 0; j < 4; j++) begin
      wr(8'h18, (32'h1 << (12 + j)) | 32'h3, 2'b00);
      pulse((j + 1) % 4);
      chk("out", pins.out, 32'h0);
      pulse(j);
      chk("out", pins.out, 32'h3);
      repeat (20) @(posedge aclk);
      chk("out", pins.out, 32'h3);
      wr(8'h1c, 32'h0, 2'b00);
      pulse(j);
      chk("out", pins.out, 32'h0);
      wr(8'h1c, 32'h3, 2'b00);
    end
    // counting, clock gate, request flag and mask; full rate, flag cleared first
    wr(8'h18, 32'h0, 2'b00);
    wr(8'h04, 32'h0, 2'b00);
    wr(8'h08, 32'h0, 2'b00);
    wr(8'h20, 32'h3, 2'b00);
    wr(8'h10, 32'h80, 2'b00);
    rchk(8'h2c, 32'hffff, 32'hffff);
    wr(8'h00, 32'h1, 2'b00);
    repeat (20) @(posedge aclk);
    rchk(8'h08, 32'h20, 32'h20);
    rd(8'h2c, v);
    chk("cnt", 32'(v[15:0] <= 16'h3), 32'h1);
    wr(8'h0c, 32'h0, 2'b00);
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, irq_pending}, 32'h1);
    wr(8'h0c, 32'h20, 2'b00);
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, irq_pending}, 32'h0);
    // output split over 16 cycles: standalone, interleaved, output zero active low
    wr(8'h24, 32'h2, 2'b00);
    for (j = 0; j < 3; j++) begin
      wr(8'h14, (j == 2) ? 32'h4 : 32'h0, 2'b00);
      wr(8'h10, (j == 1) ? 32'h83 : 32'h80, 2'b00);
      l = 0;
      repeat (16) begin
        @(posedge aclk);
        l += int'(pins.out[0] !== pins.out[1]);
      end
      chk("split", l, j * 8);
    end
    // stop two ends at the next period end while the timer runs
    wr(8'h18, 32'h1003, 2'b00);
    pulse(0);
    rchk(8'h2c, 32'hf0000, 32'h0);
    wr(8'h18, 32'h0, 2'b00);
    wr(8'h10, 32'h0, 2'b00);
    rchk(8'h2c, 32'hffff, 32'hffff);
    wr(8'h08, 32'h0, 2'b00);
    rchk(8'h08, 32'h20, 32'h0);
    // count rate per prescaler code; step 6 uses the second prescaler at /8
    wr(8'h20, 32'hffff, 2'b00);
    for (i = 0; i < 7; i++) begin
      wr(8'h04, (i < 6) ? i : 32'h30, 2'b00);
      wr(8'h10, (i < 6) ? 32'h80 : 32'h90, 2'b00);
      rd(8'h2c, v);
      repeat (40) @(posedge aclk);
      rd(8'h2c, v2);
      dv = int'(16'(v2[15:0] - v[15:0]));
      // 43 clock edges lie between the two counter samples
      e = 43 >> ((i < 6) ? i : 3);
      chk("rate", 32'(dv >= e - 1 && dv <= e + 1), 32'h1);
      wr(8'h10, 32'h0, 2'b00);
    end
    finish_test();
  end
endmodule
